// ---- rtl/hipm_clk_gen.sv ----
// glitch-free processor clock generator, divided fast clock or slow oscillator
`default_nettype none
module hipm_clk_gen (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [1:0] div_sel_i,
	input wire logic slow_sel_i,
	input wire logic rtc_level_i,
	output logic clk_out_o,
	output logic clk_out_alt_o,
	output logic slow_active_o
);
	logic [3:0] cnt_r;
	logic [3:0] half_r;
	logic [3:0] half_nxt;
	logic out_nxt;
	logic switch_ok;

	always_comb begin
		case (div_sel_i)
			hipm_pkg::DIV_8: half_nxt = hipm_pkg::HALF_8;
			hipm_pkg::DIV_32: half_nxt = hipm_pkg::HALF_32;
			default: half_nxt = hipm_pkg::HALF_2;
		endcase
	end

	// source or rate changes only while the output sits low, so no runt pulse
	assign switch_ok = !clk_out_o && (slow_active_o ? !rtc_level_i : (cnt_r == half_r));

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			slow_active_o <= 1'b0;
			half_r <= hipm_pkg::HALF_2;
		end else if (switch_ok) begin
			slow_active_o <= slow_sel_i;
			half_r <= half_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r <= 4'h0;
		end else if (slow_active_o || cnt_r == half_r) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_comb begin
		if (slow_active_o) begin
			out_nxt = rtc_level_i;
		end else if (cnt_r == half_r) begin
			out_nxt = !clk_out_o;
		end else begin
			out_nxt = clk_out_o;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			clk_out_o <= 1'b0;
			clk_out_alt_o <= 1'b0;
		end else begin
			clk_out_o <= out_nxt;
			clk_out_alt_o <= out_nxt;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/hipm_pkg.sv ----
// shared constants and types of the halt and idle power manager
`default_nettype none
package hipm_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int DELAY_UNIT_NS = 1000000;
	localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;
	localparam int RESET_PULSE_CYC = 16;
	localparam int RTC_DIV_1024 = 32;
	localparam int RTC_DIV_16 = 2048;
	localparam logic [4:0] DIV_MASK_1024 = 5'h1F;
	localparam logic [10:0] DIV_MASK_16 = 11'h7FF;

	// register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_IDLE = 8'h0C;
	localparam logic [7:0] REG_SMI = 8'h10;

	// reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [5:0] MASK_RESET = 6'h00;
	localparam logic [11:0] IDLE_RESET = 12'hFFF;

	// status bit positions
	localparam int ST_HALT_SEEN = 0;
	localparam int ST_IDLE_ZERO = 1;
	localparam int ST_WAKE = 2;
	localparam int ST_SHUTDOWN = 3;
	localparam int ST_SMI = 4;
	localparam int ST_DEEP = 5;
	localparam int ST_W = 6;

	// software trigger bit in the smi register
	localparam int SMI_SW_BIT = 0;

	// halt options
	localparam logic [1:0] HALT_READY = 2'h0;
	localparam logic [1:0] HALT_SMI = 2'h1;
	localparam logic [1:0] HALT_DEEP = 2'h2;

	// clock divider codes and half periods in system cycles, less one
	localparam logic [1:0] DIV_2 = 2'h0;
	localparam logic [1:0] DIV_8 = 2'h1;
	localparam logic [1:0] DIV_32 = 2'h2;
	localparam logic [3:0] HALF_2 = 4'h0;
	localparam logic [3:0] HALF_8 = 4'h3;
	localparam logic [3:0] HALF_32 = 4'hF;

	typedef struct packed {
		logic [5:0] delay_sel;
		logic cs_act_en;
		logic act_en;
		logic ext_smi_en;
		logic idle_smi_en;
		logic idle_rate;
		logic [1:0] clk_div;
		logic stop_clock_request_en;
		logic [1:0] halt_opt;
	} hipm_ctrl_t;

	typedef struct packed {
		logic valid;
		logic halt;
		logic shutdown;
		logic stop_grant;
	} hipm_cycle_t;

	typedef enum logic [1:0] {
		PM_RUN = 2'h0,
		PM_STOPREQ = 2'h1,
		PM_DEEP = 2'h3,
		PM_RELOCK = 2'h2
	} hipm_state_t;
endpackage
`default_nettype wire

// ---- rtl/hipm_top.sv ----
// halt and idle power manager: halt handling, deep sleep, idle timer, smi
// Operation
// R1: halt option two answers halt with ready and raises a management interrupt.
// R2: halt option three: ready, stop request, on stop grant slow clock and self-refresh.
// R3: deep halt asserts oscillator_off to power down the fast oscillator.
// R4: during self-refresh no isa refresh or other isa activity.
// R5: option three with stop clock enabled asserts stop request on halt detect.
// R6: in deep halt a change of interrupt or smi drops oscillator_off, fast clock back.
// R7: wait 1 to 64 ms after wake before dropping stop request.
// R8: every halt cycle sets halt_seen_flag status bit.
// R9: shutdown drives processor_init_out and isa_bus_reset for at least 16 clocks.
// R10: one idle timer counts down to zero, reloading from the idle latch.
// R11: reload when count is zero and smm_acknowledge is asserted.
// R12: reload on each external input assertion when enabled as activity strobe.
// R13: reload on each programmable chip select assertion when enabled.
// R14: timer is 12 bits, ticked at 1024 Hz or 16 Hz from 32768 Hz.
// R15: clock source switches produce no glitch or runt pulse.
// R16: timer reaching zero raises management interrupt when enabled.
// R17: management interrupt stays asserted until smm_acknowledge.
// R18: clock division 2, 8 or 32; division by 2 after reset.
`default_nettype none
module hipm_top #(
	parameter int UNIT_CYC = hipm_pkg::DELAY_UNIT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire hipm_pkg::hipm_cycle_t cpu_cycle_i,
	input wire logic cpu_int_request_i,
	input wire logic external_event_input_i,
	input wire logic smm_acknowledge_i,
	input wire logic chip_select_i,
	input wire logic rtc_osc_i,
	output logic cpu_ready_o,
	output logic stop_clock_request_o,
	output logic oscillator_off_o,
	output logic dram_self_refresh_o,
	output logic isa_quiet_o,
	output logic processor_init_out_o,
	output logic isa_bus_reset_o,
	output logic mgmt_interrupt_out_o,
	output logic cpu_clock_out_o,
	output logic cpu_clock_out_alt_o,
	output logic irq_o
);
	hipm_pkg::hipm_ctrl_t ctrl_r;
	hipm_pkg::hipm_state_t state_r;
	logic [hipm_pkg::ST_W-1:0] status_r;
	logic [hipm_pkg::ST_W-1:0] mask_r;
	logic [hipm_pkg::ST_W-1:0] ev_set;
	logic [11:0] idle_latch_r;
	logic [11:0] idle_cnt_r;
	logic [10:0] rtc_div_r;
	logic rtc_prev_r;
	logic rtc_edge;
	logic idle_tick;
	logic idle_reload;
	logic idle_zero_ev;
	logic ext_prev_r;
	logic cs_prev_r;
	logic int_prev_r;
	logic smi_prev_r;
	logic wake_ev;
	logic smi_pend_r;
	logic ack_prev_r;
	logic sw_smi;
	logic halt_cyc;
	logic shut_cyc;
	logic grant_cyc;
	logic [4:0] rst_cnt_r;
	logic [16:0] unit_cnt_r;
	logic [6:0] ms_cnt_r;
	logic [6:0] ms_target;
	logic slow_sel;
	logic slow_active;
	logic wr_ctrl;
	logic rd_status;

	assign halt_cyc = cpu_cycle_i.valid && cpu_cycle_i.halt;
	assign shut_cyc = cpu_cycle_i.valid && cpu_cycle_i.shutdown;
	assign grant_cyc = cpu_cycle_i.valid && cpu_cycle_i.stop_grant;
	assign wr_ctrl = reg_wr_i && reg_addr_i == hipm_pkg::REG_CTRL;
	assign rd_status = reg_rd_i && reg_addr_i == hipm_pkg::REG_STATUS;
	assign sw_smi = reg_wr_i && reg_addr_i == hipm_pkg::REG_SMI && reg_wdata_i[hipm_pkg::SMI_SW_BIT];
	assign ms_target = {1'b0, ctrl_r.delay_sel} + 7'h01;

	// register writes
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_r <= hipm_pkg::CTRL_RESET;
			mask_r <= hipm_pkg::MASK_RESET;
			idle_latch_r <= hipm_pkg::IDLE_RESET;
		end else if (reg_wr_i) begin
			if (wr_ctrl) begin
				ctrl_r <= hipm_pkg::hipm_ctrl_t'(reg_wdata_i[15:0]);
			end
			if (reg_addr_i == hipm_pkg::REG_MASK) begin
				mask_r <= reg_wdata_i[hipm_pkg::ST_W-1:0];
			end
			if (reg_addr_i == hipm_pkg::REG_IDLE) begin
				idle_latch_r <= reg_wdata_i[11:0];
			end
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				hipm_pkg::REG_CTRL: reg_rdata_o <= {16'h0000, ctrl_r};
				hipm_pkg::REG_STATUS: reg_rdata_o <= {26'h000_0000, status_r};
				hipm_pkg::REG_MASK: reg_rdata_o <= {26'h000_0000, mask_r};
				hipm_pkg::REG_IDLE: reg_rdata_o <= {4'h0, idle_cnt_r, 4'h0, idle_latch_r};
				hipm_pkg::REG_SMI: reg_rdata_o <= {31'h0000_0000, mgmt_interrupt_out_o};
				default: reg_rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

	// sticky status; a same-cycle event beats the clear-on-read
	always_comb begin
		ev_set = '0;
		// R8: halt seen flag
		ev_set[hipm_pkg::ST_HALT_SEEN] = halt_cyc;
		ev_set[hipm_pkg::ST_IDLE_ZERO] = idle_zero_ev;
		ev_set[hipm_pkg::ST_WAKE] = wake_ev;
		ev_set[hipm_pkg::ST_SHUTDOWN] = shut_cyc;
		ev_set[hipm_pkg::ST_SMI] = mgmt_interrupt_out_o && !smi_prev_r;
		ev_set[hipm_pkg::ST_DEEP] = grant_cyc && state_r == hipm_pkg::PM_STOPREQ;
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			status_r <= '0;
		end else if (rd_status) begin
			status_r <= ev_set;
		end else begin
			status_r <= status_r | ev_set;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |((rd_status ? ev_set : (status_r | ev_set)) & mask_r);
		end
	end

	// R14: 1024 Hz and 16 Hz ticks from the 32768 Hz oscillator
	assign rtc_edge = rtc_osc_i && !rtc_prev_r;
	assign idle_tick = rtc_edge && (ctrl_r.idle_rate ?
		(rtc_div_r == hipm_pkg::DIV_MASK_16) :
		(rtc_div_r[4:0] == hipm_pkg::DIV_MASK_1024));

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rtc_prev_r <= 1'b0;
			rtc_div_r <= 11'h000;
		end else begin
			rtc_prev_r <= rtc_osc_i;
			if (rtc_edge) begin
				rtc_div_r <= rtc_div_r + 11'h001;
			end
		end
	end

	// R11: reload at zero when acknowledged
	// R12: reload on activity strobe
	// R13: reload on chip select
	assign idle_reload = (idle_cnt_r == 12'h000 && smm_acknowledge_i) ||
		(ctrl_r.act_en && external_event_input_i && !ext_prev_r) ||
		(ctrl_r.cs_act_en && chip_select_i && !cs_prev_r);
	assign idle_zero_ev = idle_tick && !idle_reload && idle_cnt_r == 12'h001;

	// R10: idle timer counts down, stops at zero
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			idle_cnt_r <= hipm_pkg::IDLE_RESET;
		end else if (idle_reload) begin
			idle_cnt_r <= idle_latch_r;
		end else if (idle_tick && idle_cnt_r != 12'h000) begin
			idle_cnt_r <= idle_cnt_r - 12'h001;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			ext_prev_r <= 1'b0;
			cs_prev_r <= 1'b0;
			int_prev_r <= 1'b0;
			smi_prev_r <= 1'b0;
			ack_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= external_event_input_i;
			cs_prev_r <= chip_select_i;
			int_prev_r <= cpu_int_request_i;
			smi_prev_r <= mgmt_interrupt_out_o;
			ack_prev_r <= smm_acknowledge_i;
		end
	end

	// events saved while acknowledged are raised after the acknowledge drops
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			smi_pend_r <= 1'b0;
		end else if ((halt_cyc && ctrl_r.halt_opt == hipm_pkg::HALT_SMI) ||
				(idle_zero_ev && ctrl_r.idle_smi_en) ||
				(ctrl_r.ext_smi_en && external_event_input_i && !ext_prev_r) ||
				sw_smi) begin
			// R1: halt raises management interrupt
			// R16: idle timer zero raises management interrupt
			smi_pend_r <= 1'b1;
		end else if (smm_acknowledge_i && !ack_prev_r) begin
			smi_pend_r <= 1'b0;
		end
	end

	// R17: interrupt held until acknowledge
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			mgmt_interrupt_out_o <= 1'b0;
		end else if (smm_acknowledge_i) begin
			mgmt_interrupt_out_o <= 1'b0;
		end else if (smi_pend_r) begin
			mgmt_interrupt_out_o <= 1'b1;
		end
	end

	// ready for every halt, shutdown and stop grant cycle
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			cpu_ready_o <= 1'b0;
		end else begin
			cpu_ready_o <= halt_cyc || shut_cyc || grant_cyc;
		end
	end

	// R9: shutdown reset pulse of 16 clocks
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rst_cnt_r <= 5'h00;
			processor_init_out_o <= 1'b0;
			isa_bus_reset_o <= 1'b0;
		end else if (shut_cyc) begin
			rst_cnt_r <= 5'(hipm_pkg::RESET_PULSE_CYC);
			processor_init_out_o <= 1'b1;
			isa_bus_reset_o <= 1'b1;
		end else if (rst_cnt_r != 5'h00) begin
			rst_cnt_r <= rst_cnt_r - 5'h01;
			processor_init_out_o <= rst_cnt_r != 5'h01;
			isa_bus_reset_o <= rst_cnt_r != 5'h01;
		end
	end

	// R6: wake on a change of interrupt request or management interrupt
	assign wake_ev = state_r == hipm_pkg::PM_DEEP &&
		((cpu_int_request_i != int_prev_r) || (mgmt_interrupt_out_o != smi_prev_r));

	// halt sequencer; a shutdown abandons any sleep in progress
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= hipm_pkg::PM_RUN;
		end else if (shut_cyc) begin
			state_r <= hipm_pkg::PM_RUN;
		end else begin
			case (state_r)
				hipm_pkg::PM_RUN: begin
					// R5: stop request on halt detect
					if (halt_cyc && ctrl_r.halt_opt == hipm_pkg::HALT_DEEP && ctrl_r.stop_clock_request_en) begin
						state_r <= hipm_pkg::PM_STOPREQ;
					end
				end
				hipm_pkg::PM_STOPREQ: begin
					// R2: stop grant enters deep halt
					if (grant_cyc) begin
						state_r <= hipm_pkg::PM_DEEP;
					end
				end
				hipm_pkg::PM_DEEP: begin
					if (wake_ev) begin
						state_r <= hipm_pkg::PM_RELOCK;
					end
				end
				hipm_pkg::PM_RELOCK: begin
					// R7: restart delay before stop request drops
					if (ms_cnt_r == ms_target) begin
						state_r <= hipm_pkg::PM_RUN;
					end
				end
				default: state_r <= hipm_pkg::PM_RUN;
			endcase
		end
	end

	// R7: millisecond counter for the restart delay
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			unit_cnt_r <= 17'h00000;
			ms_cnt_r <= 7'h00;
		end else if (state_r != hipm_pkg::PM_RELOCK) begin
			unit_cnt_r <= 17'h00000;
			ms_cnt_r <= 7'h00;
		end else if (unit_cnt_r == 17'(UNIT_CYC - 1)) begin
			unit_cnt_r <= 17'h00000;
			ms_cnt_r <= ms_cnt_r + 7'h01;
		end else begin
			unit_cnt_r <= unit_cnt_r + 17'h00001;
		end
	end

	// stop request and oscillator_off follow the next state so they move with the transition
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			stop_clock_request_o <= 1'b0;
			oscillator_off_o <= 1'b0;
			dram_self_refresh_o <= 1'b0;
			isa_quiet_o <= 1'b0;
		end else if (shut_cyc) begin
			stop_clock_request_o <= 1'b0;
			oscillator_off_o <= 1'b0;
			dram_self_refresh_o <= 1'b0;
			isa_quiet_o <= 1'b0;
		end else begin
			// R5: stop request from halt until restart delay ends
			if (state_r == hipm_pkg::PM_RUN && halt_cyc &&
					ctrl_r.halt_opt == hipm_pkg::HALT_DEEP && ctrl_r.stop_clock_request_en) begin
				stop_clock_request_o <= 1'b1;
			end else if (state_r == hipm_pkg::PM_RELOCK && ms_cnt_r == ms_target) begin
				stop_clock_request_o <= 1'b0;
			end
			// R3: oscillator off in deep halt
			// R6: dropped at once on wake
			if (state_r == hipm_pkg::PM_STOPREQ && grant_cyc) begin
				oscillator_off_o <= 1'b1;
			end else if (wake_ev) begin
				oscillator_off_o <= 1'b0;
			end
			// R2: self-refresh from stop grant
			// R4: isa quiet while self-refresh
			// dram stays in self-refresh until the fast clock is back
			if (state_r == hipm_pkg::PM_STOPREQ && grant_cyc) begin
				dram_self_refresh_o <= 1'b1;
				isa_quiet_o <= 1'b1;
			end else if (state_r == hipm_pkg::PM_RELOCK && !slow_active) begin
				dram_self_refresh_o <= 1'b0;
				isa_quiet_o <= 1'b0;
			end
		end
	end

	// R2: slow clock in deep halt
	// R6: fast clock divided by 2 after wake
	assign slow_sel = state_r == hipm_pkg::PM_DEEP && !wake_ev;

	// R15: glitch-free switching
	// R18: software divider, by 2 at reset and after wake
	hipm_clk_gen u_clk_gen (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.div_sel_i(state_r == hipm_pkg::PM_RUN ? ctrl_r.clk_div : hipm_pkg::DIV_2),
		.slow_sel_i(slow_sel),
		.rtc_level_i(rtc_osc_i),
		.clk_out_o(cpu_clock_out_o),
		.clk_out_alt_o(cpu_clock_out_alt_o),
		.slow_active_o(slow_active)
	);
endmodule
`default_nettype wire

// ---- verification/hipm_cpu_model.sv ----
// processor model: special cycles, stop grant, smm acknowledge
`default_nettype none
module hipm_cpu_model (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [1:0] req_i,
	input wire logic slow_i,
	input wire logic stop_clock_request_i,
	input wire logic smi_i,
	output hipm_pkg::hipm_cycle_t cycle_o,
	output logic ack_o
);
	logic [1:0] stp_r;
	logic [3:0] cnt_r;
	// stop grant one cycle pulse after a stop request rises
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			cycle_o <= 4'h0;
			stp_r <= 2'h0;
		end else begin
			stp_r <= {stp_r[0], stop_clock_request_i};
			cycle_o <= {(|req_i) || stp_r == 2'h1, req_i, stp_r == 2'h1};
		end
	end
	// slow answer: processor finishes a long instruction before smm
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r <= 4'h0;
			ack_o <= 1'b0;
		end else if (!ack_o && smi_i && cnt_r == (slow_i ? 4'h9 : 4'h1)) begin
			ack_o <= 1'b1;
			cnt_r <= 4'h0;
		end else if (ack_o && cnt_r == 4'h3) begin
			ack_o <= 1'b0;
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= (smi_i || ack_o) ? cnt_r + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// ---- verification/hipm_monitor.sv ----
// port checker of the halt and idle power manager
`default_nettype none
module hipm_monitor (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire hipm_pkg::hipm_cycle_t cpu_cycle_i,
	input wire logic cpu_int_request_i,
	input wire logic smm_acknowledge_i,
	input wire logic cpu_ready_o,
	input wire logic stop_clock_request_o,
	input wire logic oscillator_off_o,
	input wire logic dram_self_refresh_o,
	input wire logic isa_quiet_o,
	input wire logic processor_init_out_o,
	input wire logic isa_bus_reset_o,
	input wire logic mgmt_interrupt_out_o,
	input wire logic cpu_clock_out_o,
	input wire logic cpu_clock_out_alt_o
);
	hipm_pkg::hipm_ctrl_t ctrl_r;
	logic [5:0] div2_r;
	// shadow of the control word, seen only through bus writes
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_r <= 16'h0000;
		end else if (reg_wr_i && reg_addr_i == hipm_pkg::REG_CTRL) begin
			ctrl_r <= reg_wdata_i[15:0];
		end
	end
	// settle time: a rate switch back to divide by 2 may wait for the slower half period to end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			div2_r <= 6'h00;
		end else if (ctrl_r.clk_div != hipm_pkg::DIV_2 || dram_self_refresh_o) begin
			div2_r <= 6'h00;
		end else if (div2_r != 6'h28) begin
			div2_r <= div2_r + 6'h01;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	sequence s_halt(logic [1:0] opt);
		cpu_cycle_i.valid && cpu_cycle_i.halt && ctrl_r.halt_opt == opt;
	endsequence
	sequence s_rst16;
		(processor_init_out_o && isa_bus_reset_o)[*8] ##1
			(processor_init_out_o && isa_bus_reset_o)[*8];
	endsequence
	sequence s_relock;
		stop_clock_request_o[*8] ##[1:700] !stop_clock_request_o;
	endsequence
	a_ready_pulse: assert property (cpu_cycle_i.valid |=> cpu_ready_o)
		else $error("no ready after special cycle");
	a_halt_smi: assert property (s_halt(hipm_pkg::HALT_SMI) ##0 !smm_acknowledge_i
		##1 !smm_acknowledge_i |-> ##[1:2] mgmt_interrupt_out_o) else $error("halt gave no smi");
	a_stop_halt: assert property (s_halt(hipm_pkg::HALT_DEEP) ##0 ctrl_r.stop_clock_request_en
		&& !stop_clock_request_o |=> stop_clock_request_o) else $error("no stop request");
	a_deep_entry: assert property (cpu_cycle_i.valid && cpu_cycle_i.stop_grant
		&& stop_clock_request_o && !oscillator_off_o |=> oscillator_off_o && dram_self_refresh_o)
		else $error("stop grant did not enter deep halt");
	a_quiet_isa: assert property (dram_self_refresh_o |-> isa_quiet_o)
		else $error("isa active during self-refresh");
	a_wake_osc: assert property (oscillator_off_o && $changed(cpu_int_request_i)
		|=> !oscillator_off_o) else $error("oscillator kept off after wake");
	a_relock_wait: assert property ($fell(oscillator_off_o) && !processor_init_out_o
		|-> s_relock) else $error("stop request timing after wake");
	a_shut_reset: assert property (cpu_cycle_i.valid && cpu_cycle_i.shutdown
		|=> s_rst16) else $error("reset pulse short");
	a_smi_hold: assert property (mgmt_interrupt_out_o && !smm_acknowledge_i
		|=> mgmt_interrupt_out_o) else $error("smi dropped before ack");
	a_clk_twin: assert property (cpu_clock_out_o == cpu_clock_out_alt_o)
		else $error("clock outputs differ");
	a_div2_toggle: assert property (div2_r == 6'h28 |-> $changed(cpu_clock_out_o))
		else $error("clock not divided by two");
endmodule
bind hipm_top hipm_monitor i_mon (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.cpu_cycle_i, .cpu_int_request_i, .smm_acknowledge_i, .cpu_ready_o, .stop_clock_request_o,
	.oscillator_off_o, .dram_self_refresh_o, .isa_quiet_o, .processor_init_out_o,
	.isa_bus_reset_o, .mgmt_interrupt_out_o, .cpu_clock_out_o, .cpu_clock_out_alt_o);
`default_nettype wire

// ---- verification/hipm_tb_top.sv ----
// self-checking bench of the halt and idle power manager
`default_nettype none
module hipm_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i, reset_i, reg_wr_i, reg_rd_i, cpu_int_request_i, rtc_run, slow;
	logic external_event_input_i, smm_acknowledge_i, chip_select_i, cpu_ready_o, irq_o;
	logic stop_clock_request_o, oscillator_off_o, dram_self_refresh_o, isa_quiet_o;
	logic processor_init_out_o, isa_bus_reset_o, mgmt_interrupt_out_o;
	logic cpu_clock_out_o, cpu_clock_out_alt_o;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic [1:0] req, rtc_cnt;
	hipm_pkg::hipm_cycle_t cpu_cycle_i;
	int miscompares, checks_done, n;
	hipm_top #(.UNIT_CYC(10)) i_dut (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .cpu_cycle_i, .cpu_int_request_i,
		.external_event_input_i, .smm_acknowledge_i, .chip_select_i, .rtc_osc_i(rtc_cnt[1]),
		.cpu_ready_o, .stop_clock_request_o, .oscillator_off_o, .dram_self_refresh_o,
		.isa_quiet_o, .processor_init_out_o, .isa_bus_reset_o, .mgmt_interrupt_out_o,
		.cpu_clock_out_o, .cpu_clock_out_alt_o, .irq_o);
	hipm_cpu_model i_cpu (.clk_sys_i, .reset_i, .req_i(req), .slow_i(slow),
		.stop_clock_request_i(stop_clock_request_o), .smi_i(mgmt_interrupt_out_o), .cycle_o(cpu_cycle_i),
		.ack_o(smm_acknowledge_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	// slow oscillator at a quarter of the system clock, gated to pin timer ticks
	always @(posedge clk_sys_i) if (rtc_run) rtc_cnt <= rtc_cnt + 2'h1;
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", w, e, g);
		end
	endtask
	task automatic await(input string w, ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge clk_sys_i);
			n++;
		end
		if (s !== v) begin
			miscompares++;
			$display("BAD %s exp level got timeout", w);
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_sys_i);
		chk(w, e, reg_rdata_o);
	endtask
	task automatic cpu(input logic [1:0] k);
		@(posedge clk_sys_i);
		req <= k;
		@(posedge clk_sys_i);
		req <= 2'h0;
		@(negedge clk_sys_i);
		@(negedge clk_sys_i);
		chk("ready", 1'b1, cpu_ready_o);
	endtask
	task automatic t_reset();
		logic c;
		rd(hipm_pkg::REG_CTRL, 32'h0, "ctrl");
		rd(hipm_pkg::REG_MASK, 32'h0, "mask");
		rd(hipm_pkg::REG_IDLE, 32'h0FFF0FFF, "idle");
		rd(8'h14, 32'h0, "unmapped");
		c = cpu_clock_out_o;
		@(negedge clk_sys_i);
		chk("div2", !c, cpu_clock_out_o);
	endtask
	task automatic t_halt_ready();
		cpu(2'h2);
		chk("irq masked", 1'b0, irq_o);
		rd(hipm_pkg::REG_STATUS, 32'h01, "status");
		rd(hipm_pkg::REG_STATUS, 32'h00, "cleared");
	endtask
	task automatic t_halt_smi();
		wr(hipm_pkg::REG_MASK, 32'h10);
		wr(hipm_pkg::REG_CTRL, 32'h1);
		slow <= 1'b1;
		cpu(2'h2);
		await("smi", mgmt_interrupt_out_o, 1'b1, 5);
		// irq follows the status bit, one cycle behind the smi pin
		@(negedge clk_sys_i);
		chk("irq", 1'b1, irq_o);
		await("smi end", mgmt_interrupt_out_o, 1'b0, 30);
		chk("smi wait", 1'b1, n > 9);
		rd(hipm_pkg::REG_STATUS, 32'h11, "status");
		chk("irq clr", 1'b0, irq_o);
		slow <= 1'b0;
	endtask
	task automatic t_deep();
		wr(hipm_pkg::REG_CTRL, 32'h0406);
		cpu(2'h2);
		chk("stop req", 1'b1, stop_clock_request_o);
		await("oscillator_off", oscillator_off_o, 1'b1, 20);
		chk("self refresh", 1'b1, dram_self_refresh_o);
		chk("isa quiet", 1'b1, isa_quiet_o);
		repeat (30) @(posedge clk_sys_i);
		cpu_int_request_i <= 1'b1;
		@(negedge clk_sys_i);
		@(negedge clk_sys_i);
		chk("osc on", 1'b0, oscillator_off_o);
		await("relock", stop_clock_request_o, 1'b0, 200);
		chk("relock", 1'b1, n >= 17 && n <= 22);
		await("refresh end", dram_self_refresh_o, 1'b0, 100);
		@(posedge clk_sys_i);
		cpu_int_request_i <= 1'b0;
		rd(hipm_pkg::REG_STATUS, 32'h25, "status");
	endtask
	task automatic t_shut();
		cpu(2'h1);
		chk("isa reset", 1'b1, isa_bus_reset_o);
		await("init", processor_init_out_o, 1'b0, 40);
		chk("init len", 32'h10, n);
		rd(hipm_pkg::REG_STATUS, 32'h08, "status");
	endtask
	task automatic t_idle();
		wr(hipm_pkg::REG_MASK, 32'h0);
		wr(hipm_pkg::REG_CTRL, 32'h0340);
		wr(hipm_pkg::REG_IDLE, 32'h2);
		external_event_input_i <= 1'b1;
		wr(hipm_pkg::REG_IDLE, 32'h2);
		external_event_input_i <= 1'b0;
		rd(hipm_pkg::REG_IDLE, 32'h00020002, "activity");
		rtc_run <= 1'b1;
		await("idle smi", mgmt_interrupt_out_o, 1'b1, 400);
		chk("tick rate", 1'b1, n > 120 && n < 265);
		@(posedge clk_sys_i);
		rtc_run <= 1'b0;
		await("idle ack", mgmt_interrupt_out_o, 1'b0, 20);
		rd(hipm_pkg::REG_IDLE, 32'h00020002, "ack reload");
		rd(hipm_pkg::REG_STATUS, 32'h12, "status");
		wr(hipm_pkg::REG_IDLE, 32'h5);
		chip_select_i <= 1'b1;
		@(posedge clk_sys_i);
		chip_select_i <= 1'b0;
		rd(hipm_pkg::REG_IDLE, 32'h00050005, "cs reload");
	endtask
	task automatic t_sw_smi();
		wr(hipm_pkg::REG_CTRL, 32'h80);
		wr(hipm_pkg::REG_SMI, 32'h1);
		await("sw smi", mgmt_interrupt_out_o, 1'b1, 5);
		rd(hipm_pkg::REG_SMI, 32'h1, "smi level");
		await("sw ack", mgmt_interrupt_out_o, 1'b0, 20);
		@(posedge clk_sys_i);
		external_event_input_i <= 1'b1;
		await("ext smi", mgmt_interrupt_out_o, 1'b1, 5);
		await("ext ack", mgmt_interrupt_out_o, 1'b0, 20);
		@(posedge clk_sys_i);
		external_event_input_i <= 1'b0;
		rd(hipm_pkg::REG_STATUS, 32'h10, "smi status");
	endtask
	task automatic t_div();
		logic c;
		for (int k = 1; k < 3; k++) begin
			wr(hipm_pkg::REG_CTRL, {27'h0, k[1:0], 3'h0});
			repeat (40) @(negedge clk_sys_i);
			c = cpu_clock_out_o;
			await("edge", cpu_clock_out_o, !c, 40);
			await("half", cpu_clock_out_o, c, 40);
			chk("half", k == 1 ? hipm_pkg::HALF_8 + 5'h1 : hipm_pkg::HALF_32 + 5'h1, n);
		end
		wr(hipm_pkg::REG_CTRL, 32'h0);
	endtask
	initial begin
		reset_i = 1'b1;
		{reg_wr_i, reg_rd_i, cpu_int_request_i, rtc_run, slow} = 5'h00;
		{external_event_input_i, chip_select_i, req, rtc_cnt} = 6'h00;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		t_reset();
		t_halt_ready();
		t_halt_smi();
		t_deep();
		t_shut();
		t_idle();
		t_sw_smi();
		t_div();
		final_report();
	end
endmodule
`default_nettype wire
